// *** rtl/spi_frame_rx.sv ***
// spi slave shift logic on the link clock, mode 0, msb first
`timescale 1ns/100ps
`default_nettype none
`include "wetting_regs.svh"
module spi_frame_rx (
  input wire logic spiClk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [`FRAME_BITS-1:0] replyWord,
  output logic miso,
  output logic [`FRAME_BITS-1:0] frame,
  output logic frameToggle
);
  logic [5:0] bitCnt_q;
  logic [`FRAME_BITS-1:0] shift_q;
  logic [`FRAME_BITS-1:0] reply_q;
  logic loaded_q;

  // chip select clears the count asynchronously, the clock idles between frames
  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      bitCnt_q <= 6'h00;
      shift_q <= 32'h0000_0000;
    end else begin
      // [RL18] 32-bit frame capture
      shift_q <= {shift_q[`FRAME_BITS-2:0], mosi};
      bitCnt_q <= bitCnt_q + 6'h01;
    end
  end

  assign frame = shift_q;

  // done flag rises after bit 31 and is cleared by chip select, so it starts
  // every frame low and the core sees one rising edge per full frame
  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      reply_q <= 32'h0000_0000;
      loaded_q <= 1'b0;
      frameToggle <= 1'b0;
    end else begin
      // first falling edge loads the word past its top bit, later ones shift
      reply_q <= loaded_q ? {reply_q[`FRAME_BITS-2:0], 1'b0}
                          : {replyWord[`FRAME_BITS-2:0], 1'b0};
      loaded_q <= 1'b1;
      if (bitCnt_q == 6'(`FRAME_BITS)) begin
        frameToggle <= 1'b1;
      end
    end
  end

  assign miso = loaded_q ? reply_q[`FRAME_BITS-1] : replyWord[`FRAME_BITS-1];
endmodule
`default_nettype wire

// *** rtl/wetting_irq_bank.sv ***
// wetting timers, continuous-wetting and interrupt enable registers over spi
`timescale 1ns/100ps
`default_nettype none
`include "wetting_regs.svh"
// Operation
// [RL1] each input owns a 20 ms timer; only the ground inputs have one here, the programmable inputs have none
// [RL2] timer starts on threshold crossing
// [RL3] expiry drops ground current to sustain
// [RL4] cleared bit: elevated then sustain
// [RL5] set bit holds full wetting current
// [RL6] continuous bits reset to zero
// [RL7] continuous register writable in normal mode
// [RL8] cleared enable blocks input interrupt
// [RL9] set enable raises interrupt on change
// [RL10] all enable bits reset to one
// [RL11] enable registers writable in normal mode
// [RL12] address 0x0C ground continuous wetting
// [RL13] address 0x0D programmable interrupt enable
// [RL14] address 0x0E ground interrupt enable
// [RL15] three-bit code selects wetting level
// [RL16] bit 23 follows live fault
// [RL17] bit 22 set on interrupt event
// [RL18] frame: address, rw flag, data
// [RL19] reply: fault, flag, 22 data bits
// [RL20] status and unused bits ignore writes
module wetting_irq_bank
  import wetting_pkg::*;
#(
  parameter int GND_N = `GND_INPUTS,
  parameter int PROG_N = `PROG_INPUTS,
  parameter int WET_CYCLES = `WET_TIME_MS * `CLK_KHZ
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  input wire logic [GND_N-1:0] gndClosed,
  input wire logic [PROG_N-1:0] progClosed,
  input wire logic [3*GND_N-1:0] gndLevelCode,
  input wire logic faultPresent,
  input wire logic normalMode,
  input wire logic irqFlagClear,
  output logic [3*GND_N-1:0] gndDriveCode,
  output logic [GND_N-1:0] gndContinuous,
  output logic [PROG_N-1:0] progIrqEnable,
  output logic [GND_N-1:0] gndIrqEnable,
  output logic globalInterruptFlag,
  output logic irqEvent
);
  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [GND_N-1:0] gndMeta_q, gndSync_q, gndPrev_q;
  logic [PROG_N-1:0] progMeta_q, progSync_q, progPrev_q;
  logic faultMeta_q, faultSync_q;
  logic togMeta_q, togSync_q, togPrev_q;
  logic csMeta_q, csSync_q;
  logic frameToggle;
  logic [`FRAME_BITS-1:0] frame;
  logic [`FRAME_BITS-1:0] replyWord;
  logic rawMiso;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gndMeta_q <= '0;
      gndSync_q <= '0;
      gndPrev_q <= '0;
      progMeta_q <= '0;
      progSync_q <= '0;
      progPrev_q <= '0;
      faultMeta_q <= 1'b0;
      faultSync_q <= 1'b0;
      togMeta_q <= 1'b0;
      togSync_q <= 1'b0;
      togPrev_q <= 1'b0;
      csMeta_q <= 1'b1;
      csSync_q <= 1'b1;
    end else begin
      gndMeta_q <= gndClosed;
      gndSync_q <= gndMeta_q;
      gndPrev_q <= gndSync_q;
      progMeta_q <= progClosed;
      progSync_q <= progMeta_q;
      progPrev_q <= progSync_q;
      faultMeta_q <= faultPresent;
      faultSync_q <= faultMeta_q;
      togMeta_q <= frameToggle;
      togSync_q <= togMeta_q;
      togPrev_q <= togSync_q;
      csMeta_q <= csN;
      csSync_q <= csMeta_q;
    end
  end

  logic [GND_N-1:0] gndChange;
  logic [PROG_N-1:0] progChange;
  assign gndChange = gndSync_q ^ gndPrev_q;
  assign progChange = progSync_q ^ progPrev_q;

  //////////////////////////////////////////////////////////////////////////
  // spi link on its own clock
  spi_frame_rx u_rx (
    .spiClk(spiClk),
    .csN(csN),
    .mosi(mosi),
    .replyWord(replyWord),
    .miso(rawMiso),
    .frame(frame),
    .frameToggle(frameToggle)
  );

  // the done flag rises once per full frame; chip select must stay low for
  // at least three core cycles after the last falling link edge, because
  // the link clears its shift register as soon as chip select rises
  logic frameDone;
  assign frameDone = togSync_q & ~togPrev_q;

  // capture the frame once it has crossed, then decode from this copy
  logic [`FRAME_BITS-1:0] frameHold_q, frameHold_d;
  logic apply_q, apply_d;

  always_comb begin
    frameHold_d = frameHold_q;
    apply_d = frameDone;
    if (frameDone) begin
      frameHold_d = frame;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frameHold_q <= 32'h0000_0000;
      apply_q <= 1'b0;
    end else begin
      frameHold_q <= frameHold_d;
      apply_q <= apply_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file
  // selector codes returned by the address decoder
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CONT = 2'h1;
  localparam logic [1:0] SEL_PROG = 2'h2;
  localparam logic [1:0] SEL_GND = 2'h3;

  function automatic logic [1:0] decode(input logic [6:0] addr);
    case (addr)
      `ADDR_GND_CONT_WET: decode = SEL_CONT;
      `ADDR_PROG_INT_EN: decode = SEL_PROG;
      `ADDR_GND_INT_EN: decode = SEL_GND;
      default: decode = SEL_NONE;
    endcase
  endfunction

  logic [GND_N-1:0] contWet_q, contWet_d;
  logic [PROG_N-1:0] progEn_q, progEn_d;
  logic [GND_N-1:0] gndEn_q, gndEn_d;
  logic [6:0] lastAddr_q, lastAddr_d;
  logic flag_q, flag_d;
  logic fault_q, fault_d;
  logic irqEvent_d;
  logic [6:0] wAddr;
  logic [`REG_BITS-1:0] wData;

  assign wAddr = frameHold_q[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  assign wData = frameHold_q[`REG_BITS-1:0];

  always_comb begin
    contWet_d = contWet_q;
    progEn_d = progEn_q;
    gndEn_d = gndEn_q;
    lastAddr_d = lastAddr_q;
    flag_d = flag_q;
    // [RL16] fault bit tracks live fault
    fault_d = faultSync_q;
    // [RL8] [RL9] enabled changes only
    irqEvent_d = normalMode &&
                 (|(gndChange & gndEn_q) || |(progChange & progEn_q));
    if (apply_q) begin
      // [RL18] address and rw decode
      lastAddr_d = wAddr;
      // [RL7] [RL11] writes accepted in normal mode
      if (frameHold_q[`FRAME_RW_BIT] && normalMode) begin
        // [RL20] only register bits are stored
        case (decode(wAddr))
          // [RL12] ground continuous wetting
          SEL_CONT: contWet_d = wData[GND_N-1:0];
          // [RL13] programmable enables
          SEL_PROG: progEn_d = wData[PROG_N-1:0];
          // [RL14] ground enables
          SEL_GND: gndEn_d = wData[GND_N-1:0];
          default: lastAddr_d = wAddr;
        endcase
      end
    end
    // [RL17] event sets flag, set beats clear
    if (irqFlagClear) begin
      flag_d = 1'b0;
    end
    if (irqEvent_d) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      // [RL6] pulse operation after reset
      contWet_q <= `RST_GND_CONT_WET;
      // [RL10] all enables after reset
      progEn_q <= `RST_PROG_INT_EN;
      gndEn_q <= `RST_GND_INT_EN;
      lastAddr_q <= 7'h00;
      flag_q <= 1'b0;
      fault_q <= 1'b0;
      irqEvent <= 1'b0;
    end else begin
      contWet_q <= contWet_d;
      progEn_q <= progEn_d;
      gndEn_q <= gndEn_d;
      lastAddr_q <= lastAddr_d;
      flag_q <= flag_d;
      fault_q <= fault_d;
      irqEvent <= irqEvent_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reply word, held stable in the core domain; the link samples it at the
  // start of the next frame, so replies lag one frame as usual for such parts
  logic [`REG_BITS-1:0] regData;
  logic [`FRAME_BITS-1:0] reply_q, reply_d;

  always_comb begin
    regData = '0;
    // [RL19] unused bits read zero
    case (decode(lastAddr_q))
      SEL_CONT: regData[GND_N-1:0] = contWet_q;
      SEL_PROG: regData[PROG_N-1:0] = progEn_q;
      SEL_GND: regData[GND_N-1:0] = gndEn_q;
      default: regData = '0;
    endcase
    reply_d = reply_q;
    // update only while idle so the link never samples a moving word
    if (csSync_q) begin
      reply_d = {lastAddr_q, 1'b0, fault_q, flag_q, regData};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reply_q <= 32'h0000_0000;
    end else begin
      reply_q <= reply_d;
    end
  end

  assign replyWord = reply_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      miso <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      miso <= rawMiso;
      misoOe <= ~csSync_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-input wetting timers
  genvar gi;
  generate
    for (gi = 0; gi < GND_N; gi++) begin : g_timer
      wetting_timer #(.WET_CYCLES(WET_CYCLES)) u_tmr (
        .core_clk(core_clk),
        .srst(srst),
        .crossed(gndChange[gi]),
        .continuousWet(contWet_q[gi]),
        // [RL15] level code passes to driver
        .levelCode(gndLevelCode[3*gi +: 3]),
        .driveCode(gndDriveCode[3*gi +: 3])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gndContinuous <= `RST_GND_CONT_WET;
      progIrqEnable <= `RST_PROG_INT_EN;
      gndIrqEnable <= `RST_GND_INT_EN;
      globalInterruptFlag <= 1'b0;
    end else begin
      gndContinuous <= contWet_q;
      progIrqEnable <= progEn_q;
      gndIrqEnable <= gndEn_q;
      globalInterruptFlag <= flag_q;
    end
  end
endmodule
`default_nettype wire

// *** rtl/wetting_pkg.sv ***
// types shared by the wetting and interrupt enable bank
package wetting_pkg;
  typedef enum logic [1:0] {
    WET_IDLE,
    WET_ELEVATED,
    WET_SUSTAIN
  } wet_state_t;
  typedef enum logic {
    LINK_RX,
    LINK_DONE
  } link_state_t;
endpackage

// *** rtl/wetting_regs.svh ***
// register addresses, field layout, reset values and timing for the bank
`ifndef WETTING_REGS_SVH
`define WETTING_REGS_SVH
`define ADDR_GND_CONT_WET 7'h0C
`define ADDR_PROG_INT_EN 7'h0D
`define ADDR_GND_INT_EN 7'h0E
`define FRAME_BITS 32
`define FRAME_ADDR_HI 31
`define FRAME_ADDR_LO 25
`define FRAME_RW_BIT 24
`define FRAME_DATA_HI 23
`define FAULT_BIT 23
`define IRQ_FLAG_BIT 22
`define REG_BITS 22
`define GND_INPUTS 21
`define PROG_INPUTS 12
`define RST_GND_CONT_WET 21'h00_0000
`define RST_GND_INT_EN 21'h1F_FFFF
`define RST_PROG_INT_EN 12'hFFF
`define WET_TIME_MS 20
`define CLK_KHZ 100000
`define LEVEL_CODE_DEFAULT 3'h6
`define LEVEL_CODE_SUSTAIN 3'h0
`endif

// *** rtl/wetting_timer.sv ***
// one input's wetting timer and current-level selection
`timescale 1ns/100ps
`default_nettype none
`include "wetting_regs.svh"
module wetting_timer
  import wetting_pkg::*;
#(
  parameter int WET_CYCLES = `WET_TIME_MS * `CLK_KHZ
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic crossed,
  input wire logic continuousWet,
  input wire logic [2:0] levelCode,
  output logic [2:0] driveCode
);
  wet_state_t state_q, state_d;
  logic [31:0] count_q, count_d;
  logic [2:0] drive_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    drive_d = `LEVEL_CODE_SUSTAIN;
    case (state_q)
      WET_IDLE: begin
        // [RL2] timer start on crossing
        if (crossed) begin
          state_d = WET_ELEVATED;
          count_d = 32'h0000_0000;
        end
      end
      WET_ELEVATED: begin
        // [RL1] independent 20 ms count
        if (crossed) begin
          count_d = 32'h0000_0000;
        end else if (count_q < WET_CYCLES - 1) begin
          count_d = count_q + 32'h0000_0001;
        end else if (!continuousWet) begin
          // [RL4] pulse mode ends elevation
          state_d = WET_SUSTAIN;
        end
      end
      WET_SUSTAIN: begin
        // a fresh crossing restarts elevation
        if (crossed) begin
          state_d = WET_ELEVATED;
          count_d = 32'h0000_0000;
        end else if (continuousWet) begin
          state_d = WET_ELEVATED;
        end
      end
      default: state_d = WET_IDLE;
    endcase
    // [RL5] continuous keeps full level
    // [RL3] sustain level after expiry
    if (state_d == WET_ELEVATED || state_d == WET_IDLE) begin
      drive_d = levelCode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= WET_IDLE;
      count_q <= 32'h0000_0000;
      driveCode <= `LEVEL_CODE_DEFAULT;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      driveCode <= drive_d;
    end
  end
endmodule
`default_nettype wire

// *** tb/spi_host_model.sv ***
// host spi master model sending 32-bit mode 0 frames
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic spiClk,
  output logic csN,
  output logic mosi,
  input wire logic miso
);
  localparam real HALF = 62.5;
  // select starts low and rises at 1 ns, so the link counters see a clear
  // edge whatever order the time-zero processes run in
  initial begin
    spiClk = 1'b0;
    csN = 1'b0;
    mosi = 1'b0;
    #1;
    csN = 1'b1;
  end
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    csN = 1'b0;
    #(HALF);
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF);
      spiClk = 1'b1;
      rx[i] = miso;
      #(HALF);
      spiClk = 1'b0;
    end
    #(HALF);
    csN = 1'b1;
    // released line flips so a stale bit never looks valid
    mosi = ~mosi;
    #(4 * HALF);
  endtask
endmodule
`default_nettype wire

// *** tb/wetting_irq_bank_assertions.sv ***
// concurrent checks on the wetting and interrupt enable bank ports
`timescale 1ns/100ps
`default_nettype none
module wetting_irq_bank_assertions #(
  parameter int GND_N = 21,
  parameter int PROG_N = 12,
  parameter int WET_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic csN,
  input wire logic misoOe,
  input wire logic [GND_N-1:0] gndClosed,
  input wire logic [3*GND_N-1:0] gndLevelCode,
  input wire logic normalMode,
  input wire logic [3*GND_N-1:0] gndDriveCode,
  input wire logic [GND_N-1:0] gndContinuous,
  input wire logic [PROG_N-1:0] progIrqEnable,
  input wire logic [GND_N-1:0] gndIrqEnable,
  input wire logic globalInterruptFlag,
  input wire logic irqEvent
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic prev_q;
  int quiet_q;
  // cycles since input 0 last moved, seen one cycle late
  always_ff @(posedge core_clk) begin
    prev_q <= gndClosed[0];
    quiet_q <= (srst || gndClosed[0] != prev_q) ? 0 : quiet_q + 1;
  end
  property p_rst_val;
    $past(srst) |-> gndContinuous == '0 && &gndIrqEnable && &progIrqEnable;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("register copies wrong after reset");
  property p_cont_hold;
    gndContinuous[0] [*3] ##0 $stable(gndLevelCode[2:0])
      |-> gndDriveCode[2:0] == gndLevelCode[2:0];
  endproperty
  a_cont_hold: assert property (p_cont_hold)
    else $error("continuous input lost wetting level");
  // the 4-cycle look back skips drops caused by clearing the bit
  property p_wet_time;
    $past(gndDriveCode[2:0]) != 3'h0 && gndDriveCode[2:0] == 3'h0 &&
      !$past(gndContinuous[0], 4)
      |-> quiet_q >= WET_CYCLES && quiet_q <= WET_CYCLES + 6;
  endproperty
  a_wet_time: assert property (p_wet_time)
    else $error("sustain reached at wrong time");
  property p_restart;
    $changed(gndClosed[0]) |-> ##[2:6] gndDriveCode[2:0] == gndLevelCode[2:0];
  endproperty
  a_restart: assert property (p_restart)
    else $error("crossing did not restore wetting level");
  property p_irq_on;
    $changed(gndClosed[0]) && gndIrqEnable[0] && normalMode |-> ##[2:6] irqEvent;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled change gave no event");
  property p_irq_off;
    $changed(gndClosed[0]) && !gndIrqEnable[0] &&
      $stable(gndClosed[GND_N-1:1]) |-> !irqEvent [*6];
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("disabled change gave an event");
  property p_flag_set;
    irqEvent |-> ##[0:1] globalInterruptFlag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set flag");
  property p_no_write;
    !normalMode [*8] |=> $stable(gndContinuous) && $stable(gndIrqEnable) &&
      $stable(progIrqEnable);
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("register changed outside normal mode");
  property p_oe_sel;
    $fell(csN) |-> ##[2:4] misoOe;
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("serial output not enabled during frame");
  property p_oe_off;
    $rose(csN) |-> ##[2:4] !misoOe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("serial output still enabled after frame");
endmodule
bind wetting_irq_bank wetting_irq_bank_assertions #(
  .GND_N(GND_N),
  .PROG_N(PROG_N),
  .WET_CYCLES(WET_CYCLES)
) i_wetting_irq_bank_assertions (
  .core_clk(core_clk),
  .srst(srst),
  .csN(csN),
  .misoOe(misoOe),
  .gndClosed(gndClosed),
  .gndLevelCode(gndLevelCode),
  .normalMode(normalMode),
  .gndDriveCode(gndDriveCode),
  .gndContinuous(gndContinuous),
  .progIrqEnable(progIrqEnable),
  .gndIrqEnable(gndIrqEnable),
  .globalInterruptFlag(globalInterruptFlag),
  .irqEvent(irqEvent)
);
`default_nettype wire

// *** tb/wetting_irq_bank_tb.sv ***
// self-checking bench for the wetting and interrupt enable bank
`timescale 1ns/100ps
`default_nettype none
module wetting_irq_bank_tb;
  localparam int WET = 50;
  logic core_clk, srst, spiClk, csN, mosi, miso, faultPresent, normalMode;
  logic irqFlagClear, globalInterruptFlag, irqEvent;
  logic [20:0] gndClosed, gndContinuous, gndIrqEnable;
  logic [11:0] progClosed, progIrqEnable;
  logic [62:0] gndLevelCode, gndDriveCode;
  logic [31:0] rx;
  int nFail, checksDone;
  wetting_irq_bank #(.WET_CYCLES(WET)) i_wetting_irq_bank (
    .core_clk(core_clk), .srst(srst), .spiClk(spiClk), .csN(csN),
    .mosi(mosi), .miso(miso), .misoOe(), .gndClosed(gndClosed),
    .progClosed(progClosed), .gndLevelCode(gndLevelCode),
    .faultPresent(faultPresent), .normalMode(normalMode),
    .irqFlagClear(irqFlagClear), .gndDriveCode(gndDriveCode),
    .gndContinuous(gndContinuous), .progIrqEnable(progIrqEnable),
    .gndIrqEnable(gndIrqEnable), .globalInterruptFlag(globalInterruptFlag),
    .irqEvent(irqEvent));
  spi_host_model i_spi_host_model (.spiClk(spiClk), .csN(csN), .mosi(mosi),
    .miso(miso));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // a read answers in the following frame
  task automatic rd(input logic [6:0] a, output logic [31:0] r);
    i_spi_host_model.xfer({a, 25'h0}, r);
    i_spi_host_model.xfer({7'h7F, 25'h0}, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    i_spi_host_model.xfer({a, 1'b1, d}, rx);
  endtask
  task automatic waitIrq(input logic exp);
    logic seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      seen |= irqEvent;
    end
    cmp(seen, exp);
  endtask
  task automatic tResetRegs;
    faultPresent = 1'b1;
    rd(7'h0C, rx);
    cmp(rx, {7'h0C, 3'h2, 22'h0});
    faultPresent = 1'b0;
    rd(7'h0D, rx);
    cmp(rx, {7'h0D, 3'h0, 22'h0_0FFF});
    rd(7'h0E, rx);
    cmp(rx, {7'h0E, 3'h0, 22'h1F_FFFF});
  endtask
  task automatic tRegs;
    logic [6:0] a[3] = '{7'h0C, 7'h0D, 7'h0E};
    logic [21:0] m[3] = '{22'h1F_FFFF, 22'h0_0FFF, 22'h1F_FFFF};
    logic [21:0] r[3] = '{22'h0, 22'h0_0FFF, 22'h1F_FFFF};
    for (int i = 0; i < 3; i++) begin
      wr(a[i], 24'hFF_FFFF);
      rd(a[i], rx);
      cmp(rx, {a[i], 3'h0, m[i]});
      wr(a[i], {2'h0, r[i]});
    end
    rd(7'h7F, rx);
    cmp(rx, {7'h7F, 25'h0});
  endtask
  task automatic tRefused;
    tick(1);
    normalMode = 1'b0;
    wr(7'h0E, 24'h0);
    rd(7'h0E, rx);
    cmp(rx, {7'h0E, 3'h0, 22'h1F_FFFF});
    tick(1);
    normalMode = 1'b1;
  endtask
  task automatic tWet;
    tick(1);
    gndClosed[0] = 1'b1;
    tick(WET / 2);
    cmp(gndDriveCode[5:0], 6'h36);
    tick(WET);
    cmp(gndDriveCode[5:0], 6'h30);
    wr(7'h0C, 24'h1);
    tick(1);
    gndClosed[0] = 1'b0;
    tick(2 * WET);
    cmp(gndDriveCode[5:0], 6'h36);
    wr(7'h0C, 24'h0);
    cmp(gndDriveCode[2:0], 3'h0);
  endtask
  task automatic tIrq;
    tick(1);
    irqFlagClear = 1'b0;
    gndClosed[0] = 1'b1;
    waitIrq(1'b1);
    cmp(globalInterruptFlag, 1'b1);
    irqFlagClear = 1'b1;
    tick(1);
    irqFlagClear = 1'b0;
    tick(1);
    cmp(globalInterruptFlag, 1'b0);
    wr(7'h0E, 24'h0);
    tick(1);
    gndClosed[0] = 1'b0;
    waitIrq(1'b0);
    progClosed[3] = 1'b1;
    waitIrq(1'b1);
  endtask
  task automatic reportAndStop;
    $display("checks=%0d mismatches=%0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    faultPresent = 1'b0;
    normalMode = 1'b1;
    irqFlagClear = 1'b1;
    gndClosed = 21'h0;
    progClosed = 12'h0;
    gndLevelCode = {21{3'h6}};
    nFail = 0;
    checksDone = 0;
    repeat (16) @(posedge core_clk);
    #1;
    srst = 1'b0;
    tick(4);
    tResetRegs;
    tRegs;
    tRefused;
    tWet;
    tIrq;
    reportAndStop;
  end
endmodule
`default_nettype wire
